/* include/gpc_params.svh */
// offsets, fields, reset values and counts for the pin control block
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
`define GPC_IDX_PIN_TEN 16'h4041
`define GPC_IDX_PIN_ELEVEN 16'h4042
`define GPC_IDX_INT_STATUS 16'h4050
`define GPC_IDX_INT_MASK 16'h4051
`define GPC_IDX_PIN_LEVEL 16'h4052
`define GPC_IDX_OUT_LEVEL 16'h4053
`define GPC_IDX_DEBOUNCE 16'h4054
`define GPC_BIT_DIR 15
`define GPC_BIT_PULL_HI 14
`define GPC_BIT_PULL_LO 13
`define GPC_BIT_MODE 12
`define GPC_BIT_SUPPLY 11
`define GPC_BIT_POL 10
`define GPC_BIT_OD 9
`define GPC_BIT_ENA 7
`define GPC_BIT_FN_HI 3
`define GPC_BIT_FN_LO 0
`define GPC_CTRL_RESET 16'hA400
`define GPC_CTRL_WMASK 16'hFE8F
`define GPC_PULL_NONE 2'b00
`define GPC_PULL_DOWN 2'b01
`define GPC_PULL_UP 2'b10
`define GPC_DEBOUNCE_RESET 16'h03E8
`endif

/* include/gpc_pkg.sv */
// types for the pin control block
package gpc_pkg;
    typedef logic [15:0] gpc_ctrl_t;
    typedef logic [3:0] gpc_fn_t;
    typedef enum logic [3:0] {
        GPC_IN_PLAIN_LONG = 4'h0,
        GPC_IN_PLAIN = 4'h1,
        GPC_IN_POWER_ONOFF = 4'h2,
        GPC_IN_SLEEP_WAKE = 4'h3,
        GPC_IN_SLEEP_WAKE_LONG = 4'h4,
        GPC_IN_SLEEP = 4'h5,
        GPC_IN_POWER_ON = 4'h6,
        GPC_IN_WATCHDOG = 4'h7,
        GPC_IN_DVS1 = 4'h8,
        GPC_IN_DVS2 = 4'h9,
        GPC_IN_HW_EN1 = 4'hA,
        GPC_IN_HW_EN2 = 4'hB,
        GPC_IN_HW_CTL1 = 4'hC,
        GPC_IN_HW_CTL2 = 4'hD,
        GPC_IN_HW_CTL1_LONG = 4'hE,
        GPC_IN_HW_CTL2_LONG = 4'hF
    } gpc_in_fn_t;
endpackage

/* rtl/gpc_pin_control.sv */
// two-pin general purpose pin control with apb registers
`timescale 1ns/1ns
`include "gpc_params.svh"
module gpc_pin_control (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // pins, index 0 is pin ten, 1 is pin eleven
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [1:0] pin_pull_up,
    output logic [1:0] pin_pull_down,
    // sources for output functions
    input wire logic osc_32k_clk,
    input wire logic on_state,
    input wire logic sleep_state,
    input wire logic power_state_change,
    input wire logic dvs1_done,
    input wire logic dvs2_done,
    input wire logic ext_power_enable1,
    input wire logic ext_power_enable2,
    input wire logic system_supply_good,
    input wire logic converter_power_good,
    input wire logic ext_power_clk_2m,
    input wire logic aux_reset,
    // requests from input functions
    output logic power_onoff_req,
    output logic sleep_wake_req,
    output logic sleep_req,
    output logic power_on_req,
    output logic watchdog_reset_in,
    output logic [1:0] dvs_ctrl,
    output logic [1:0] hw_enable,
    output logic [1:0] hw_control
);
    import gpc_pkg::*;

    gpc_ctrl_t ctrl_r [2];
    logic [1:0] int_status_r;
    logic [1:0] int_mask_r;
    logic [1:0] out_level_r;
    logic [15:0] debounce_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] filt_r;
    logic [1:0] filt_d_r;
    logic [15:0] deb_cnt_r [2];
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic irq_r;
    logic [1:0] pin_out_r;
    logic [1:0] pin_oe_r;
    logic [1:0] pull_up_r;
    logic [1:0] pull_down_r;
    logic [1:0] level;
    logic [1:0] is_in;
    logic [1:0] int_evt;
    logic [15:0] out_src [2];
    logic [1:0] out_val;
    logic access;
    logic wr_fire;
    logic hit_ctrl0;
    logic hit_ctrl1;
    logic hit_stat;
    logic hit_mask;
    logic hit_lvl;
    logic hit_out;
    logic hit_deb;
    logic hit_any;
    logic [31:0] rd_nxt;

    // byte address of a register index
    function automatic logic [31:0] reg_addr(input logic [15:0] idx);
        reg_addr = {14'h0000, idx, 2'b00};
    endfunction
    // functions that need the long de-bounce filter
    function automatic logic is_long(input gpc_fn_t fn);
        is_long = (fn == GPC_IN_PLAIN_LONG) ||
            (fn == GPC_IN_SLEEP_WAKE_LONG) ||
            (fn == GPC_IN_HW_CTL1_LONG) ||
            (fn == GPC_IN_HW_CTL2_LONG);
    endfunction
    // apply the polarity setting to a level
    function automatic logic polar(input logic pol, input logic v);
        polar = pol ? v : ~v;
    endfunction
    function automatic gpc_fn_t fn_of(input gpc_ctrl_t c);
        fn_of = c[`GPC_BIT_FN_HI:`GPC_BIT_FN_LO];
    endfunction
    // an enabled input pin carrying the given function
    function automatic logic in_fn(input int i, input gpc_fn_t code);
        in_fn = is_in[i] && (fn_of(ctrl_r[i]) == code) && level[i];
    endfunction
    // either pin carrying the given function
    function automatic logic any_fn(input gpc_fn_t code);
        any_fn = in_fn(0, code) | in_fn(1, code);
    endfunction

    // ---------------- apb decode ----------------
    // register address decode
    assign hit_ctrl0 = (paddr == reg_addr(`GPC_IDX_PIN_TEN));
    assign hit_ctrl1 = (paddr == reg_addr(`GPC_IDX_PIN_ELEVEN));
    assign hit_stat = (paddr == reg_addr(`GPC_IDX_INT_STATUS));
    assign hit_mask = (paddr == reg_addr(`GPC_IDX_INT_MASK));
    assign hit_lvl = (paddr == reg_addr(`GPC_IDX_PIN_LEVEL));
    assign hit_out = (paddr == reg_addr(`GPC_IDX_OUT_LEVEL));
    assign hit_deb = (paddr == reg_addr(`GPC_IDX_DEBOUNCE));
    assign hit_any = hit_ctrl0 | hit_ctrl1 | hit_stat | hit_mask |
        hit_lvl | hit_out | hit_deb;
    assign access = psel && penable && !pready_r;
    assign wr_fire = psel && penable && pready_r && pwrite && hit_any;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_ctrl0) begin
            rd_nxt = {16'h0000, ctrl_r[0]};
        end else if (hit_ctrl1) begin
            rd_nxt = {16'h0000, ctrl_r[1]};
        end else if (hit_stat) begin
            rd_nxt = {30'h0000_0000, int_status_r};
        end else if (hit_mask) begin
            rd_nxt = {30'h0000_0000, int_mask_r};
        end else if (hit_lvl) begin
            rd_nxt = {30'h0000_0000, level};
        end else if (hit_out) begin
            rd_nxt = {30'h0000_0000, out_level_r};
        end else if (hit_deb) begin
            rd_nxt = {16'h0000, debounce_r};
        end
    end

    // answer one cycle into the access phase
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= access;
            if (access) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
                pslverr_r <= !hit_any;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_r[0] <= `GPC_CTRL_RESET;
            ctrl_r[1] <= `GPC_CTRL_RESET;
        end else if (wr_fire) begin
            if (hit_ctrl0) begin
                ctrl_r[0] <= pwdata[15:0] & `GPC_CTRL_WMASK;
            end
            if (hit_ctrl1) begin
                ctrl_r[1] <= pwdata[15:0] & `GPC_CTRL_WMASK;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            int_mask_r <= 2'b00;
            out_level_r <= 2'b00;
            debounce_r <= `GPC_DEBOUNCE_RESET;
        end else if (wr_fire) begin
            if (hit_mask) begin
                int_mask_r <= pwdata[1:0];
            end
            if (hit_out) begin
                out_level_r <= pwdata[1:0];
            end
            if (hit_deb) begin
                debounce_r <= pwdata[15:0];
            end
        end
    end

    // ---------------- input path ----------------
    // two-stage synchroniser
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sync1_r <= 2'b00;
            sync2_r <= 2'b00;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            filt_r <= 2'b00;
            filt_d_r <= 2'b00;
            deb_cnt_r[0] <= 16'h0000;
            deb_cnt_r[1] <= 16'h0000;
        end else begin
            filt_d_r <= filt_r;
            for (int i = 0; i < 2; i++) begin
                if (!is_long(fn_of(ctrl_r[i]))) begin
                    filt_r[i] <= sync2_r[i];
                    deb_cnt_r[i] <= 16'h0000;
                end else if (sync2_r[i] == filt_r[i]) begin
                    deb_cnt_r[i] <= 16'h0000;
                end else if (deb_cnt_r[i] >= debounce_r) begin
                    filt_r[i] <= sync2_r[i];
                    deb_cnt_r[i] <= 16'h0000;
                end else begin
                    deb_cnt_r[i] <= deb_cnt_r[i] + 16'h0001;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            level[i] = polar(ctrl_r[i][`GPC_BIT_POL], filt_r[i]);
            is_in[i] = ctrl_r[i][`GPC_BIT_ENA] && ctrl_r[i][`GPC_BIT_DIR];
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (ctrl_r[i][`GPC_BIT_MODE]) begin
                int_evt[i] = is_in[i] && (filt_r[i] != filt_d_r[i]);
            end else if (ctrl_r[i][`GPC_BIT_POL]) begin
                int_evt[i] = is_in[i] && filt_r[i] && !filt_d_r[i];
            end else begin
                int_evt[i] = is_in[i] && !filt_r[i] && filt_d_r[i];
            end
        end
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            int_status_r <= 2'b00;
        end else if (wr_fire && hit_stat) begin
            int_status_r <= (int_status_r & ~pwdata[1:0]) | int_evt;
        end else begin
            int_status_r <= int_status_r | int_evt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_status_r & int_mask_r);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            power_onoff_req <= 1'b0;
            sleep_wake_req <= 1'b0;
            sleep_req <= 1'b0;
            power_on_req <= 1'b0;
            watchdog_reset_in <= 1'b0;
            dvs_ctrl <= 2'b00;
            hw_enable <= 2'b00;
            hw_control <= 2'b00;
        end else begin
            power_onoff_req <= any_fn(GPC_IN_POWER_ONOFF);
            sleep_wake_req <= any_fn(GPC_IN_SLEEP_WAKE) |
                any_fn(GPC_IN_SLEEP_WAKE_LONG);
            sleep_req <= any_fn(GPC_IN_SLEEP);
            power_on_req <= any_fn(GPC_IN_POWER_ON);
            watchdog_reset_in <= any_fn(GPC_IN_WATCHDOG);
            dvs_ctrl <= {any_fn(GPC_IN_DVS2), any_fn(GPC_IN_DVS1)};
            hw_enable <= {any_fn(GPC_IN_HW_EN2), any_fn(GPC_IN_HW_EN1)};
            hw_control[0] <= any_fn(GPC_IN_HW_CTL1) |
                any_fn(GPC_IN_HW_CTL1_LONG);
            hw_control[1] <= any_fn(GPC_IN_HW_CTL2) |
                any_fn(GPC_IN_HW_CTL2_LONG);
        end
    end

    // ---------------- output path ----------------
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            out_src[i] = {aux_reset, ext_power_clk_2m,
                converter_power_good, system_supply_good,
                ext_power_enable2, ext_power_enable1,
                dvs2_done, dvs1_done, 3'b000,
                power_state_change, sleep_state, on_state,
                osc_32k_clk, out_level_r[i]};
            out_val[i] = polar(ctrl_r[i][`GPC_BIT_POL],
                out_src[i][fn_of(ctrl_r[i])]);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_out_r <= 2'b00;
            pin_oe_r <= 2'b00;
            pull_up_r <= 2'b00;
            pull_down_r <= 2'b11;
        end else begin
            for (int i = 0; i < 2; i++) begin
                pull_up_r[i] <= ctrl_r[i][`GPC_BIT_PULL_HI:`GPC_BIT_PULL_LO]
                    == `GPC_PULL_UP;
                pull_down_r[i] <=
                    ctrl_r[i][`GPC_BIT_PULL_HI:`GPC_BIT_PULL_LO]
                    == `GPC_PULL_DOWN;
                pin_out_r[i] <= !ctrl_r[i][`GPC_BIT_OD] && out_val[i];
                pin_oe_r[i] <= ctrl_r[i][`GPC_BIT_ENA] &&
                    !ctrl_r[i][`GPC_BIT_DIR] &&
                    (!ctrl_r[i][`GPC_BIT_OD] || !out_val[i]);
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pin_pull_up = pull_up_r;
    assign pin_pull_down = pull_down_r;

endmodule // gpc_pin_control

/* tb/gpc_pin_control_assertions.sv */
// port checker for the pin control block
`timescale 1ns/1ns
module gpc_pin_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // interrupt and pins
    input wire logic irq,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] pin_pull_up,
    input wire logic [1:0] pin_pull_down
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_ready_wait:
        assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_idle:
        assert property (!psel |=> !pready)
        else $error("ready without select");
    a_error_ready:
        assert property (pslverr |-> pready && psel && penable)
        else $error("error outside answer");
    a_error_zero:
        assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_read_hold:
        assert property (pready |=> $stable(prdata))
        else $error("read data moved");
    a_pull_single:
        assert property ((pin_pull_up & pin_pull_down) == 2'h0)
        else $error("both pulls on");
    a_reset_state:
        assert property ($rose(rst_b) |-> pin_oe == 2'h0 && !irq
            && pin_pull_down == 2'h3 && pin_pull_up == 2'h0)
        else $error("bad state after reset");
    c_refused: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_drive: cover property ($rose(pin_oe[0]));
endmodule // gpc_pin_checker

bind gpc_pin_control gpc_pin_checker u_chk (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down)
);

/* tb/gpc_pin_partner.sv */
// far-side pin model: external drivers, pulls and floating wires
`timescale 1ns/1ns
module gpc_pin_partner (
    // clock
    input wire logic clock,
    // design side
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] pin_pull_up,
    input wire logic [1:0] pin_pull_down,
    // external driver
    input wire logic [1:0] ext_en,
    input wire logic [1:0] ext_val,
    output logic [1:0] pin_in
);
    logic [1:0] float_r = 2'h1;
    // an undriven, unpulled wire wanders every cycle
    always_ff @(posedge clock) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 :
                float_r[i];
        end
    end
endmodule // gpc_pin_partner

/* tb/test_gpio_pin_control_10_11.sv */
// self-checking bench for the pin control block
`timescale 1ns/1ns
`include "gpc_params.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    failures++; $display("wrong value %s expected %h seen %h", nm, ex, \
    got); end end
module test_gpio_pin_control_10_11;
    logic clock = 1'b0;
    logic rst_b, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [31:0] paddr, pwdata, prdata, rdata;
    logic [1:0] pin_in, pin_out, pin_oe, pu, pd, ext_en, ext_val;
    logic [15:0] src;
    logic [10:0] req;
    int failures, checked;
    always #2 clock = ~clock;
    gpc_pin_control dut (.clock(clock), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_up(pu), .pin_pull_down(pd), .osc_32k_clk(src[1]),
        .on_state(src[2]), .sleep_state(src[3]),
        .power_state_change(src[4]), .dvs1_done(src[8]),
        .dvs2_done(src[9]), .ext_power_enable1(src[10]),
        .ext_power_enable2(src[11]), .system_supply_good(src[12]),
        .converter_power_good(src[13]), .ext_power_clk_2m(src[14]),
        .aux_reset(src[15]), .power_onoff_req(req[0]),
        .sleep_wake_req(req[1]), .sleep_req(req[2]),
        .power_on_req(req[3]), .watchdog_reset_in(req[4]),
        .dvs_ctrl(req[6:5]), .hw_enable(req[8:7]), .hw_control(req[10:9]));
    gpc_pin_partner far (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_up(pu), .pin_pull_down(pd), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));
    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask
    // one apb transfer; byte address is four times the index
    task automatic apb(input logic wr, input logic [15:0] i,
            input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {14'h0, i, 2'h0};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
    endtask
    task automatic t_regs();
        apb(1'b0, `GPC_IDX_PIN_TEN, 32'h0);
        `CHK("ten ctrl", 32'h0000_A400, rdata)
        apb(1'b0, `GPC_IDX_PIN_ELEVEN, 32'h0);
        `CHK("eleven ctrl", 32'h0000_A400, rdata)
        apb(1'b0, `GPC_IDX_DEBOUNCE, 32'h0);
        `CHK("debounce", {16'h0000, `GPC_DEBOUNCE_RESET}, rdata)
        `CHK("drive", 2'h0, pin_oe)
        `CHK("pull down", 2'h3, pd)
        apb(1'b1, `GPC_IDX_PIN_TEN, 32'hFFFF_FFFF);
        apb(1'b0, `GPC_IDX_PIN_TEN, 32'h0);
        `CHK("ten bits", 32'h0000_FE8F, rdata)
        apb(1'b0, 16'h4060, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdata)
        $display("register test done");
    endtask
    task automatic t_pull();
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, `GPC_IDX_PIN_ELEVEN, 32'h0000_8400 | (p << 13));
            cyc(3);
            `CHK("pull up", p == 2, pu[1])
            `CHK("pull down", p == 1, pd[1])
        end
        $display("pull test done");
    endtask
    task automatic t_out();
        for (int c = 0; c < 16; c++) begin
            src <= 16'h0;
            apb(1'b1, `GPC_IDX_OUT_LEVEL, 32'h0);
            apb(1'b1, `GPC_IDX_PIN_TEN, 32'h0000_0480 | c);
            cyc(3);
            `CHK("out low", 1'b0, pin_out[0])
            src <= 16'h1 << c;
            apb(1'b1, `GPC_IDX_OUT_LEVEL, 32'h1);
            cyc(3);
            `CHK("out high", c < 5 || c > 7, pin_out[0])
            `CHK("out drive", 1'b1, pin_oe[0])
        end
        apb(1'b1, `GPC_IDX_PIN_TEN, 32'h0000_0680);
        cyc(3);
        `CHK("drain release", 1'b0, pin_oe[0])
        apb(1'b1, `GPC_IDX_PIN_TEN, 32'h0000_0280);
        cyc(3);
        `CHK("drain low", 2'h2, {pin_oe[0], pin_out[0]})
        apb(1'b1, `GPC_IDX_PIN_TEN, 32'h0000_0400);
        cyc(3);
        `CHK("tri-state", 1'b0, pin_oe[0])
        $display("output test done");
    endtask
    task automatic t_edge();
        logic [15:0] tbl;
        logic [3:0] e;
        tbl = 16'hBF16;
        apb(1'b1, `GPC_IDX_INT_MASK, 32'h1);
        ext_en <= 2'h3;
        for (int i = 0; i < 4; i++) begin
            e = tbl[4*i +: 4];
            ext_val <= 2'h0;
            apb(1'b1, `GPC_IDX_PIN_TEN,
                32'h0000_8081 | (e[3] << 12) | (e[2] << 10));
            cyc(8);
            apb(1'b1, `GPC_IDX_INT_STATUS, 32'h3);
            ext_val <= 2'h1;
            cyc(8);
            `CHK("irq", e[1], irq)
            apb(1'b0, `GPC_IDX_INT_STATUS, 32'h0);
            `CHK("rise event", e[1], rdata[0])
            apb(1'b1, `GPC_IDX_INT_STATUS, 32'h3);
            ext_val <= 2'h0;
            cyc(8);
            apb(1'b0, `GPC_IDX_INT_STATUS, 32'h0);
            `CHK("fall event", e[0], rdata[0])
        end
        apb(1'b1, `GPC_IDX_INT_MASK, 32'h0);
        cyc(2);
        `CHK("masked irq", 1'b0, irq)
        apb(1'b1, `GPC_IDX_INT_STATUS, 32'h3);
        $display("edge test done");
    endtask
    task automatic t_req();
        logic [10:0] want;
        for (int c = 2; c < 14; c++) begin
            if (c != 4) begin
                want = 11'h1 << (c < 4 ? c - 2 : c - 3);
                ext_val <= 2'h0;
                apb(1'b1, `GPC_IDX_PIN_ELEVEN, 32'h0000_8480 | c);
                cyc(6);
                ext_val <= 2'h2;
                cyc(6);
                `CHK("request", want, req)
            end
        end
        apb(1'b1, `GPC_IDX_PIN_ELEVEN, 32'h0000_840D);
        cyc(6);
        `CHK("disabled request", 11'h0, req)
        $display("request test done");
    endtask
    // long codes 14, 15, 4 and 0: level bit and requests
    task automatic t_long();
        logic [15:0] fns;
        logic [47:0] want;
        fns = 16'h04FE;
        want = {12'h800, 12'h802, 12'hC00, 12'hA00};
        apb(1'b1, `GPC_IDX_DEBOUNCE, 32'h4);
        for (int k = 0; k < 4; k++) begin
            ext_val <= 2'h0;
            apb(1'b1, `GPC_IDX_PIN_TEN, 32'h0000_8480 | fns[4*k +: 4]);
            cyc(12);
            ext_val <= 2'h1;
            cyc(3);
            ext_val <= 2'h0;
            cyc(12);
            apb(1'b0, `GPC_IDX_PIN_LEVEL, 32'h0);
            `CHK("short pulse", 12'h0, {rdata[0], req})
            ext_val <= 2'h1;
            cyc(12);
            apb(1'b0, `GPC_IDX_PIN_LEVEL, 32'h0);
            `CHK("long", want[12*k +: 12], {rdata[0], req})
        end
        $display("debounce test done");
    endtask
    task automatic t_reset();
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        apb(1'b0, `GPC_IDX_PIN_TEN, 32'h0);
        `CHK("ctrl after reset", 32'h0000_A400, rdata)
        `CHK("req after reset", 11'h0, req)
        $display("reset test done");
    endtask
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        ext_en = 2'h0;
        ext_val = 2'h0;
        src = 16'h0;
        failures = 0;
        checked = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        t_regs();
        t_pull();
        t_out();
        t_edge();
        t_req();
        t_long();
        t_reset();
        results();
    end
endmodule // test_gpio_pin_control_10_11
